//--- erx_pkg.sv
// package for the ethernet receive filter, watermark and irq enable block
package erx_pkg;

	// register word offsets, byte addressed
	localparam logic [7:0] OFS_FILTER     = 8'h00; // rx_filter_config
	localparam logic [7:0] OFS_WATERMARKS = 8'h04; // rx_watermarks
	localparam logic [7:0] OFS_IRQ_ENABLE = 8'h08; // irq_enable
	localparam logic [7:0] OFS_STATUS     = 8'h0C; // count and flags
	localparam logic [7:0] OFS_CONTROL    = 8'h10; // receiver and count control

	// reset values
	localparam logic [15:0] RST_FILTER     = 16'h0000;
	localparam logic [7:0]  RST_WATERMARK  = 8'h00;
	localparam logic [14:0] RST_IRQ_ENABLE = 15'h0000;

	// filter config bit positions
	localparam int FC_BCAST     = 0;
	localparam int FC_MCAST     = 1;
	localparam int FC_NOTME     = 2;
	localparam int FC_UCAST     = 3;
	localparam int FC_RUNT_REJ  = 4;
	localparam int FC_RUNT_COL  = 5;
	localparam int FC_CRC_OK    = 6;
	localparam int FC_CRC_ERR   = 7;
	localparam int FC_PM_LO     = 8;
	localparam int FC_NOT_PM    = 12;
	localparam int FC_WAKEUP    = 14;
	localparam int FC_HASH      = 15;
	localparam logic [15:0] FC_MASK = 16'hDFFF; // bit 13 unimplemented

	// watermark field positions
	localparam int WM_FULL_LO  = 16;
	localparam int WM_EMPTY_LO = 0;

	// interrupt bit positions
	localparam int IRQ_PKTPEND = 6;
	localparam int IRQ_FWM     = 8;
	localparam int IRQ_EWM     = 9;
	localparam logic [14:0] IEN_MASK = 15'h63EF; // implemented enables

	// status and control field positions
	localparam int ST_FLOW     = 0;
	localparam int ST_COUNT_LO = 16;
	localparam int CT_DEC      = 0;
	localparam int CT_AUTO_FC  = 1;
	localparam int CT_RX_EN    = 8;

	// a frame shorter than this many bytes is a runt
	localparam logic [15:0] RUNT_BYTES = 16'h0040;
	localparam logic [7:0]  COUNT_MAX  = 8'hFF;

	// pattern match modes
	typedef enum logic [3:0] {
		PM_OFF, PM_CSUM, PM_STA2, PM_STA3, PM_UNI4, PM_UNI5,
		PM_BC6, PM_BC7, PM_HASH, PM_WAKE
	} erx_pm_e;

	// end-of-frame summary from the mac receive path
	typedef struct packed {
		logic [15:0] length;        // bytes in frame
		logic        crc_ok;        // crc valid
		logic [47:0] dest;          // destination, first byte in [47:40]
		logic        station_match; // dest equals station address
		logic        hash_match;    // hash table hit
		logic        wakeup_match;  // wake-up frame detected
		logic        csum_match;    // pattern checksum matched
		logic [7:0]  desc_used;     // descriptors the frame used
	} erx_frame_s;

endpackage : erx_pkg

//--- erx_rx_ctrl.sv
// receive filter, buffer count watermarks and interrupt enable gating
//
// Behaviour
// - bad-crc collect set accepts only frames with invalid crc.
// - good-crc require set accepts only frames with valid crc.
// - short collect accepts only runts; with good-crc require runt needs valid crc.
// - short reject set drops every frame under 64 bytes.
// - station filter accepts unicast frames addressed to this station.
// - other-station filter accepts unicast frames addressed elsewhere.
// - group filter accepts every multicast frame.
// - all-ones filter accepts every broadcast frame.
// - pattern modes use hash or wake-up match even when those filters are off.
// - full watermark in bits 23-16 drives full flag and flow start.
// - empty watermark in bits 7-0 drives empty flag and flow stop.
// - irq enable bits 14 and 13 gate transmit and receive bus errors.
// - irq enable bits 9 and 8 gate empty and full watermark events.
// - irq enable bits 7, 6, 5 gate done, pending and activity.
// - irq enable bits 3 and 2 gate transmit done and abort.
// - irq enable bits 1 and 0 gate descriptor shortage and overflow.
// - unimplemented bits of watermark and enable registers read zero.
// - count grows by descriptors of each accepted frame, drops per decrement, saturating at 0 and 255; both in one cycle leave it unchanged.
// - full flag set while count is at or above full watermark.
// - empty flag set while count is at or below empty watermark.
//
// The placing of the registers and the address-and-strobe port were decided locally.
`timescale 1ns/1ps

module erx_rx_ctrl (
	input  wire logic               I_REF_CLK,      // 40 MHz clock
	input  wire logic               I_NRST,         // async reset, low
	input  wire logic [7:0]         I_ADDR,         // register byte address
	input  wire logic [31:0]        I_WDATA,        // write data
	input  wire logic               I_WR,           // write strobe
	input  wire logic               I_RD,           // read strobe
	input  wire logic               I_FRAME_VALID,  // end of frame pulse
	input  wire erx_pkg::erx_frame_s I_FRAME,       // frame summary
	input  wire logic [14:0]        I_IRQ_PENDING,  // other request flags
	output logic [31:0]             O_RDATA,        // read data
	output logic                    O_FRAME_ACCEPT, // frame kept, pulse
	output logic                    O_FRAME_REJECT, // frame dropped, pulse
	output logic                    O_FLOW_CTRL,    // flow control active
	output logic                    O_IRQ           // controller interrupt
);

	////////////////////////////////////////////////////////////////////////
	// registers

	logic [15:0] filter_cfg;
	logic [7:0]  full_watermark;
	logic [7:0]  empty_watermark;
	logic [14:0] irq_en;
	logic        receiver_enable;
	logic        auto_fc;
	logic [7:0]  rx_buffer_count;
	logic        full_watermark_flag;
	logic        empty_watermark_flag;

	logic wr_filter;
	logic wr_wm;
	logic wr_ien;
	logic wr_ctl;
	logic buffer_count_decrement;

	assign wr_filter = I_WR && (I_ADDR == erx_pkg::OFS_FILTER);
	assign wr_wm     = I_WR && (I_ADDR == erx_pkg::OFS_WATERMARKS);
	assign wr_ien    = I_WR && (I_ADDR == erx_pkg::OFS_IRQ_ENABLE);
	assign wr_ctl    = I_WR && (I_ADDR == erx_pkg::OFS_CONTROL);
	assign buffer_count_decrement = wr_ctl && I_WDATA[erx_pkg::CT_DEC];

	// filter config; writes are not blocked while receiving, software
	// is trusted to stop the receiver first
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			filter_cfg <= erx_pkg::RST_FILTER;
		end else if (wr_filter) begin
			filter_cfg <= I_WDATA[15:0] & erx_pkg::FC_MASK;
		end
	end

	// watermarks; ordering of the two is left to software
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			full_watermark  <= erx_pkg::RST_WATERMARK;
			empty_watermark <= erx_pkg::RST_WATERMARK;
		end else if (wr_wm) begin
			full_watermark  <= I_WDATA[erx_pkg::WM_FULL_LO +: 8];
			empty_watermark <= I_WDATA[erx_pkg::WM_EMPTY_LO +: 8];
		end
	end

	// interrupt enables, unimplemented positions held at zero
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			irq_en <= erx_pkg::RST_IRQ_ENABLE;
		end else if (wr_ien) begin
			irq_en <= I_WDATA[14:0] & erx_pkg::IEN_MASK;
		end
	end

	// control: receiver enable and automatic flow control
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			receiver_enable <= 1'b0;
			auto_fc         <= 1'b0;
		end else if (wr_ctl) begin
			receiver_enable <= I_WDATA[erx_pkg::CT_RX_EN];
			auto_fc         <= I_WDATA[erx_pkg::CT_AUTO_FC];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// frame filter

	logic is_bcast;
	logic is_mcast;
	logic is_ucast;
	logic is_short;
	logic runt_hit;
	logic must_ok;
	logic pm_base;
	logic pm_ok;
	logic any_match;
	logic accept_now;

	// first address byte bit 0 is the group bit; all ones is broadcast
	assign is_bcast = &I_FRAME.dest;
	assign is_mcast = I_FRAME.dest[40] && !is_bcast;
	assign is_ucast = !I_FRAME.dest[40];
	assign is_short = I_FRAME.length < erx_pkg::RUNT_BYTES;
	assign runt_hit = is_short
		&& (!filter_cfg[erx_pkg::FC_CRC_OK] || I_FRAME.crc_ok);

	// every enabled must-filter has to pass
	assign must_ok =
		(!filter_cfg[erx_pkg::FC_CRC_ERR] || !I_FRAME.crc_ok)
		&& (!filter_cfg[erx_pkg::FC_CRC_OK] || I_FRAME.crc_ok)
		&& (!filter_cfg[erx_pkg::FC_RUNT_COL] || runt_hit)
		&& (!filter_cfg[erx_pkg::FC_RUNT_REJ] || !is_short);

	assign pm_base = filter_cfg[erx_pkg::FC_NOT_PM] ^ I_FRAME.csum_match;

	// pattern modes take hash and wake-up hits raw, not through their
	// own enables
	always_comb begin
		unique case (erx_pkg::erx_pm_e'(filter_cfg[erx_pkg::FC_PM_LO +: 4]))
			erx_pkg::PM_CSUM: pm_ok = pm_base;
			erx_pkg::PM_STA2,
			erx_pkg::PM_STA3: pm_ok = pm_base && I_FRAME.station_match;
			erx_pkg::PM_UNI4,
			erx_pkg::PM_UNI5: pm_ok = pm_base && is_ucast;
			erx_pkg::PM_BC6,
			erx_pkg::PM_BC7:  pm_ok = pm_base && is_bcast;
			erx_pkg::PM_HASH: pm_ok = pm_base && I_FRAME.hash_match;
			erx_pkg::PM_WAKE: pm_ok = pm_base && I_FRAME.wakeup_match;
			default:          pm_ok = 1'b0; // off and unused codes
		endcase
	end

	// at least one enabled acceptance filter must match
	assign any_match =
		(filter_cfg[erx_pkg::FC_UCAST] && is_ucast
			&& I_FRAME.station_match)
		|| (filter_cfg[erx_pkg::FC_NOTME] && is_ucast
			&& !I_FRAME.station_match)
		|| (filter_cfg[erx_pkg::FC_MCAST] && is_mcast)
		|| (filter_cfg[erx_pkg::FC_BCAST] && is_bcast)
		|| (filter_cfg[erx_pkg::FC_HASH] && I_FRAME.hash_match)
		|| (filter_cfg[erx_pkg::FC_WAKEUP] && I_FRAME.wakeup_match)
		|| pm_ok;

	// a halted receive path (count saturated under flow control) drops
	assign accept_now = I_FRAME_VALID && receiver_enable && must_ok
		&& any_match && !(auto_fc && rx_buffer_count == erx_pkg::COUNT_MAX);

	// verdict pulses one cycle after the frame summary
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_FRAME_ACCEPT <= 1'b0;
			O_FRAME_REJECT <= 1'b0;
		end else begin
			O_FRAME_ACCEPT <= accept_now;
			O_FRAME_REJECT <= I_FRAME_VALID && !accept_now;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// buffer count and watermarks

	logic       count_inc;
	logic [8:0] count_sum;

	assign count_inc = accept_now && (I_FRAME.desc_used != 8'h00);
	assign count_sum = {1'b0, rx_buffer_count} + {1'b0, I_FRAME.desc_used};

	// saturates both ways; increment and decrement together cancel out
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			rx_buffer_count <= 8'h00;
		end else if (count_inc && !buffer_count_decrement) begin
			rx_buffer_count <= count_sum[8] ? erx_pkg::COUNT_MAX
				: count_sum[7:0];
		end else if (buffer_count_decrement && !count_inc
			&& rx_buffer_count != 8'h00) begin
			rx_buffer_count <= rx_buffer_count - 8'h01;
		end
	end

	// flags are sticky; the clearing event loses to a live condition
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			full_watermark_flag  <= 1'b0;
			empty_watermark_flag <= 1'b0;
		end else begin
			full_watermark_flag <= (rx_buffer_count >= full_watermark)
				|| (full_watermark_flag && !buffer_count_decrement);
			empty_watermark_flag <= (rx_buffer_count <= empty_watermark)
				|| (empty_watermark_flag && !count_inc);
		end
	end

	// flow control starts at the full mark and stops at the empty mark
	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_FLOW_CTRL <= 1'b0;
		end else if (!auto_fc) begin
			O_FLOW_CTRL <= 1'b0;
		end else if (rx_buffer_count >= full_watermark) begin
			O_FLOW_CTRL <= 1'b1;
		end else if (rx_buffer_count <= empty_watermark) begin
			O_FLOW_CTRL <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// interrupt gating

	logic [14:0] pending;

	// watermark and pending bits come from this block, the rest from outside
	always_comb begin
		pending = I_IRQ_PENDING;
		pending[erx_pkg::IRQ_FWM]     = full_watermark_flag;
		pending[erx_pkg::IRQ_EWM]     = empty_watermark_flag;
		pending[erx_pkg::IRQ_PKTPEND] = rx_buffer_count != 8'h00;
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_IRQ <= 1'b0;
		end else begin
			O_IRQ <= |(pending & irq_en);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// register read, data valid the cycle after the strobe

	logic [31:0] rd_mux;

	always_comb begin
		rd_mux = 32'h0000_0000; // unmapped reads zero
		unique case (I_ADDR)
			erx_pkg::OFS_FILTER:     rd_mux[15:0] = filter_cfg;
			erx_pkg::OFS_WATERMARKS: begin
				rd_mux[erx_pkg::WM_FULL_LO +: 8]  = full_watermark;
				rd_mux[erx_pkg::WM_EMPTY_LO +: 8] = empty_watermark;
			end
			erx_pkg::OFS_IRQ_ENABLE: rd_mux[14:0] = irq_en;
			erx_pkg::OFS_STATUS:     begin
				rd_mux[erx_pkg::ST_COUNT_LO +: 8] = rx_buffer_count;
				rd_mux[14:0]                      = pending;
				rd_mux[erx_pkg::ST_FLOW]          = O_FLOW_CTRL;
			end
			erx_pkg::OFS_CONTROL:    begin
				rd_mux[erx_pkg::CT_RX_EN]   = receiver_enable;
				rd_mux[erx_pkg::CT_AUTO_FC] = auto_fc;
			end
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge I_REF_CLK or negedge I_NRST) begin
		if (!I_NRST) begin
			O_RDATA <= 32'h0000_0000;
		end else if (I_RD) begin
			O_RDATA <= rd_mux;
		end else begin
			O_RDATA <= 32'h0000_0000;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// assertions, all on the block clock and quiet while in reset

	default clocking @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_NRST);

	sequence frame_seen_s;
		I_FRAME_VALID && receiver_enable;
	endsequence

	sequence accept_next_s;
		##1 O_FRAME_ACCEPT;
	endsequence

	crc_bad_only_a: assert property (
		frame_seen_s ##0 (filter_cfg[erx_pkg::FC_CRC_ERR] && I_FRAME.crc_ok)
		|=> !O_FRAME_ACCEPT && O_FRAME_REJECT)
		else $error("good crc frame kept under bad-crc collect");

	crc_good_only_a: assert property (
		I_FRAME_VALID && filter_cfg[erx_pkg::FC_CRC_OK] && !I_FRAME.crc_ok
		|=> O_FRAME_REJECT)
		else $error("bad crc frame kept under good-crc require");

	runt_collect_a: assert property (
		I_FRAME_VALID && filter_cfg[erx_pkg::FC_RUNT_COL] && !is_short
		|=> !O_FRAME_ACCEPT)
		else $error("long frame kept under short collect");

	runt_reject_a: assert property (
		I_FRAME_VALID && filter_cfg[erx_pkg::FC_RUNT_REJ]
		&& I_FRAME.length < 16'h0040 |=> O_FRAME_REJECT)
		else $error("runt frame kept under short reject");

	bcast_accept_a: assert property (
		frame_seen_s ##0 (filter_cfg[7:4] == 4'h0
		&& filter_cfg[erx_pkg::FC_BCAST] && is_bcast && !auto_fc)
		|-> accept_next_s)
		else $error("broadcast frame dropped");

	accept_cause_a: assert property (
		O_FRAME_ACCEPT |-> $past(I_FRAME_VALID) && $past(receiver_enable)
		&& !O_FRAME_REJECT)
		else $error("accept without a frame or with receiver off");

	count_dec_a: assert property (
		buffer_count_decrement && !count_inc && rx_buffer_count != 8'h00
		|=> rx_buffer_count == $past(rx_buffer_count) - 8'h01)
		else $error("decrement did not lower the count by one");

	full_flag_a: assert property (
		rx_buffer_count >= full_watermark |=> full_watermark_flag)
		else $error("full flag missing at or above full mark");

	empty_flag_a: assert property (
		rx_buffer_count <= empty_watermark |=> empty_watermark_flag)
		else $error("empty flag missing at or below empty mark");

	flow_start_a: assert property (
		auto_fc && rx_buffer_count >= full_watermark && !wr_ctl
		|=> O_FLOW_CTRL)
		else $error("flow control not started at full mark");

	irq_gate_a: assert property (
		O_IRQ == $past(|(pending & irq_en)))
		else $error("irq output does not follow pending and enable");

	wm_zero_a: assert property (
		I_RD && I_ADDR == erx_pkg::OFS_WATERMARKS
		|=> O_RDATA[31:24] == 8'h00 && O_RDATA[15:8] == 8'h00)
		else $error("unimplemented watermark bits read nonzero");

endmodule : erx_rx_ctrl

//--- erx_mac_model.sv
// mac receive path model that hands end-of-frame summaries to the block
`timescale 1ns/1ps

module erx_mac_model (
	input  wire logic           i_clk,   // block clock
	output erx_pkg::erx_frame_s o_frame, // frame summary
	output logic                o_valid  // end of frame pulse
);
	////////////////////////////////////////////////////////////////////////
	// quiet lines at time zero
	initial begin
		o_valid = 1'b0;
		o_frame = '0;
	end

	////////////////////////////////////////////////////////////////////////
	// one summary per call, held for exactly the edge that takes it;
	// afterwards the lines show the inverse so a stale copy never matches
	task automatic send(input erx_pkg::erx_frame_s f);
		o_valid <= 1'b1;
		o_frame <= f;
		@(posedge i_clk);
		o_valid <= 1'b0;
		o_frame <= erx_pkg::erx_frame_s'(~f);
	endtask : send
endmodule : erx_mac_model

//--- tb.sv
// self-checking bench for the receive filter, watermark and irq block
`timescale 1ns/1ps

module tb;
	localparam logic [47:0] BC   = 48'hFFFF_FFFF_FFFF; // all-ones address
	localparam logic [47:0] MC   = 48'h0100_5E00_0001; // group address
	localparam logic [47:0] UC   = 48'h0200_0000_0001; // single station
	localparam logic [15:0] LONG = 16'h0064;           // 100 byte frame
	localparam logic [15:0] RUNT = 16'h003F;           // one below minimum
	localparam logic [15:0] MIN  = 16'h0040;           // minimum frame

	logic                clk;
	logic                nrst;
	logic [7:0]          addr;
	logic [31:0]         wdata;
	logic                wr_s;
	logic                rd_s;
	logic [14:0]         pend;
	logic [31:0]         rdata;
	logic                acc;
	logic                rej;
	logic                flow;
	logic                irq;
	logic                fvalid;
	erx_pkg::erx_frame_s frame;
	int                  bad_count;
	int                  samples_checked;
	int                  cycles;

	////////////////////////////////////////////////////////////////////////
	// 40 MHz clock
	initial clk = 1'b0;
	always #12.5 clk = ~clk;

	erx_mac_model mac_u (
		.i_clk   (clk),
		.o_frame (frame),
		.o_valid (fvalid)
	);

	erx_rx_ctrl dut_u (
		.I_REF_CLK      (clk),
		.I_NRST         (nrst),
		.I_ADDR         (addr),
		.I_WDATA        (wdata),
		.I_WR           (wr_s),
		.I_RD           (rd_s),
		.I_FRAME_VALID  (fvalid),
		.I_FRAME        (frame),
		.I_IRQ_PENDING  (pend),
		.O_RDATA        (rdata),
		.O_FRAME_ACCEPT (acc),
		.O_FRAME_REJECT (rej),
		.O_FLOW_CTRL    (flow),
		.O_IRQ          (irq)
	);

	////////////////////////////////////////////////////////////////////////
	// shared helpers
	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : end_of_test

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// strobe drops after its edge; the spare cycle keeps drivers apart
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr  <= a;
		wdata <= d;
		wr_s  <= 1'b1;
		@(posedge clk);
		wr_s  <= 1'b0;
		@(posedge clk);
	endtask : wr

	// read data stand only in the cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		addr <= a;
		rd_s <= 1'b1;
		@(posedge clk);
		rd_s <= 1'b0;
		#1;
		d = rdata;
		@(posedge clk);
	endtask : rd

	// flags and irq lag the count, so let them settle first
	task automatic stat(output logic [31:0] d);
		repeat (3) @(posedge clk);
		rd(erx_pkg::OFS_STATUS, d);
	endtask : stat

	task automatic lv(input logic e_irq, input logic e_flow);
		repeat (3) @(posedge clk);
		#1;
		chk(32'(irq), 32'(e_irq));
		chk(32'(flow), 32'(e_flow));
		@(posedge clk);
	endtask : lv

	// m packs station, hash, wake-up and checksum match, in that order
	function automatic erx_pkg::erx_frame_s mk(input logic [15:0] l,
		input logic c, input logic [47:0] d, input logic [3:0] m,
		input logic [7:0] u);
		mk = '{l, c, d, m[3], m[2], m[1], m[0], u};
	endfunction : mk

	task automatic fr(input erx_pkg::erx_frame_s f, input logic e);
		mac_u.send(f);
		#1;
		chk({30'h0, acc, rej}, e ? 32'h2 : 32'h1);
		@(posedge clk);
	endtask : fr

	// filter only rewritten with the receiver off
	task automatic fc(input logic [15:0] cfg, input erx_pkg::erx_frame_s f,
		input logic e);
		wr(erx_pkg::OFS_CONTROL, 32'h0000_0000);
		wr(erx_pkg::OFS_FILTER, {16'h0000, cfg});
		wr(erx_pkg::OFS_CONTROL, 32'h0000_0100);
		fr(f, e);
	endtask : fc

	////////////////////////////////////////////////////////////////////////
	// scenarios
	task automatic t_regs();
		logic [31:0] d;
		logic [7:0]  a [3];
		logic [31:0] m [3];
		a = '{erx_pkg::OFS_FILTER, erx_pkg::OFS_WATERMARKS,
			erx_pkg::OFS_IRQ_ENABLE};
		m = '{32'h0000_DFFF, 32'h00FF_00FF, 32'h0000_63EF};
		for (int i = 0; i < 3; i++) begin
			rd(a[i], d);
			chk(d, 32'h0000_0000);
			wr(a[i], 32'hFFFF_FFFF);
			rd(a[i], d);
			chk(d, m[i]);
			wr(a[i], 32'h0000_0000);
		end
		wr(8'h14, 32'hFFFF_FFFF);
		rd(8'h14, d);
		chk(d, 32'h0000_0000);
		$display("register test done");
	endtask : t_regs

	task automatic t_filt();
		wr(erx_pkg::OFS_FILTER, 32'h0000_0001);
		fr(mk(LONG, 1'b1, BC, 4'h0, 8'h00), 1'b0);
		fc(16'h0001, mk(LONG, 1'b1, BC, 4'h0, 8'h00), 1'b1);
		fc(16'h0001, mk(LONG, 1'b1, UC, 4'h0, 8'h00), 1'b0);
		fc(16'h0002, mk(LONG, 1'b1, MC, 4'h0, 8'h00), 1'b1);
		fc(16'h0002, mk(LONG, 1'b1, BC, 4'h0, 8'h00), 1'b0);
		fc(16'h0008, mk(LONG, 1'b1, UC, 4'h8, 8'h00), 1'b1);
		fc(16'h0008, mk(LONG, 1'b1, UC, 4'h0, 8'h00), 1'b0);
		fc(16'h0004, mk(LONG, 1'b1, UC, 4'h0, 8'h00), 1'b1);
		fc(16'h0004, mk(LONG, 1'b1, UC, 4'h8, 8'h00), 1'b0);
		fc(16'h0081, mk(LONG, 1'b0, BC, 4'h0, 8'h00), 1'b1);
		fc(16'h0081, mk(LONG, 1'b1, BC, 4'h0, 8'h00), 1'b0);
		fc(16'h0041, mk(LONG, 1'b1, BC, 4'h0, 8'h00), 1'b1);
		fc(16'h0041, mk(LONG, 1'b0, BC, 4'h0, 8'h00), 1'b0);
		fc(16'h0021, mk(RUNT, 1'b0, BC, 4'h0, 8'h00), 1'b1);
		fc(16'h0021, mk(MIN, 1'b0, BC, 4'h0, 8'h00), 1'b0);
		fc(16'h0061, mk(RUNT, 1'b1, BC, 4'h0, 8'h00), 1'b1);
		fc(16'h0061, mk(RUNT, 1'b0, BC, 4'h0, 8'h00), 1'b0);
		fc(16'h0011, mk(RUNT, 1'b1, BC, 4'h0, 8'h00), 1'b0);
		fc(16'h0011, mk(MIN, 1'b1, BC, 4'h0, 8'h00), 1'b1);
		fc(16'h0800, mk(LONG, 1'b1, UC, 4'h5, 8'h00), 1'b1);
		fc(16'h0800, mk(LONG, 1'b1, UC, 4'h1, 8'h00), 1'b0);
		fc(16'h0900, mk(LONG, 1'b1, UC, 4'h3, 8'h00), 1'b1);
		fc(16'h0900, mk(LONG, 1'b1, UC, 4'h1, 8'h00), 1'b0);
		// pattern modes 1, 2, 4 and 6, inversion and the two plain enables
		fc(16'h1100, mk(LONG, 1'b1, UC, 4'h0, 8'h00), 1'b1);
		fc(16'h1100, mk(LONG, 1'b1, UC, 4'h1, 8'h00), 1'b0);
		fc(16'h0200, mk(LONG, 1'b1, UC, 4'h9, 8'h00), 1'b1);
		fc(16'h0400, mk(LONG, 1'b1, MC, 4'h1, 8'h00), 1'b0);
		fc(16'h0600, mk(LONG, 1'b1, BC, 4'h1, 8'h00), 1'b1);
		fc(16'h8000, mk(LONG, 1'b1, UC, 4'h4, 8'h00), 1'b1);
		fc(16'h8000, mk(LONG, 1'b1, UC, 4'h2, 8'h00), 1'b0);
		fc(16'h4000, mk(LONG, 1'b1, UC, 4'h2, 8'h00), 1'b1);
		fc(16'h0000, mk(LONG, 1'b1, BC, 4'h0, 8'h00), 1'b0);
		$display("filter test done");
	endtask : t_filt

	task automatic t_count();
		logic [31:0] d;
		int          bits [8];
		bits = '{14, 13, 7, 5, 3, 2, 1, 0};
		wr(erx_pkg::OFS_WATERMARKS, 32'h0003_0001);
		wr(erx_pkg::OFS_FILTER, 32'h0000_0001);
		wr(erx_pkg::OFS_IRQ_ENABLE, 32'h0000_0100);
		wr(erx_pkg::OFS_CONTROL, 32'h0000_0102);
		fr(mk(LONG, 1'b1, BC, 4'h0, 8'h02), 1'b1);
		stat(d);
		chk(32'(d[23:16]), 32'h2);
		wr(erx_pkg::OFS_CONTROL, 32'h0000_0103);
		stat(d);
		chk(32'(d[9:8]), 32'h2);
		lv(1'b0, 1'b0);
		fr(mk(LONG, 1'b1, BC, 4'h0, 8'h02), 1'b1);
		stat(d);
		chk(32'(d[23:16]), 32'h3);
		chk(32'(d[8]), 32'h1);
		lv(1'b1, 1'b1);
		// decrement taken at the mark: set wins on the old count
		wr(erx_pkg::OFS_CONTROL, 32'h0000_0103);
		stat(d);
		chk(32'(d[8]), 32'h1);
		lv(1'b1, 1'b1);
		// next decrement below the mark clears the flag
		wr(erx_pkg::OFS_CONTROL, 32'h0000_0103);
		stat(d);
		chk(32'(d[8]), 32'h0);
		lv(1'b0, 1'b0);
		// increment and decrement in one cycle cancel out
		fork
			fr(mk(LONG, 1'b1, BC, 4'h0, 8'h01), 1'b1);
			wr(erx_pkg::OFS_CONTROL, 32'h0000_0103);
		join
		stat(d);
		chk(32'(d[23:16]), 32'h1);
		wr(erx_pkg::OFS_IRQ_ENABLE, 32'h0000_0200);
		lv(1'b1, 1'b0);
		wr(erx_pkg::OFS_IRQ_ENABLE, 32'h0000_0040);
		lv(1'b1, 1'b0);
		foreach (bits[i]) begin
			pend <= 15'(15'h0001 << bits[i]);
			wr(erx_pkg::OFS_IRQ_ENABLE, 32'h1 << bits[i]);
			lv(1'b1, 1'b0);
			pend <= 15'h0000;
			lv(1'b0, 1'b0);
		end
		wr(erx_pkg::OFS_IRQ_ENABLE, 32'h0000_0000);
		fr(mk(LONG, 1'b1, BC, 4'h0, 8'hFF), 1'b1);
		stat(d);
		chk(32'(d[23:16]), 32'hFF);
		fr(mk(LONG, 1'b1, BC, 4'h0, 8'h01), 1'b0);
		lv(1'b0, 1'b1);
		$display("count test done");
	endtask : t_count

	////////////////////////////////////////////////////////////////////////
	// main sequence: reset for three cycles, then the scenarios
	initial begin
		nrst = 1'b0;
		addr = 8'h00;
		wdata = 32'h0000_0000;
		wr_s = 1'b0;
		rd_s = 1'b0;
		pend = 15'h0000;
		bad_count = 0;
		samples_checked = 0;
		cycles = 0;
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		@(posedge clk);
		t_regs();
		t_filt();
		t_count();
		end_of_test();
	end

	// the tests need under two thousand cycles; far beyond that is a hang
	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			bad_count++;
			end_of_test();
		end
	end
endmodule : tb
